/* File: rtl/jciu_params.svh */
// Purpose: constants of the test-port instruction unit
// Assumes: 10 MHz pclk, test clock sampled by pclk
// Notes: codes, widths, offsets and timing counts
`ifndef JCIU_PARAMS_SVH
`define JCIU_PARAMS_SVH

`define JCIU_IR_W        6
`define JCIU_CFG_W       112
`define JCIU_QUICK_W     40
`define JCIU_SIG_W       16
`define JCIU_ID_W        32

`define JCIU_OP_EXTEST   6'h00
`define JCIU_OP_SELFULL  6'h01
`define JCIU_OP_SELQUICK 6'h02
`define JCIU_OP_ADDSIG   6'h03
`define JCIU_OP_LATCH    6'h05
`define JCIU_OP_RDCFG    6'h06
`define JCIU_OP_RDSIG    6'h0A
`define JCIU_OP_PRGSIG   6'h0B
`define JCIU_OP_PRGCFG   6'h0C
`define JCIU_OP_IDCODE   6'h0D
`define JCIU_OP_PRGFUSE  6'h11
`define JCIU_OP_PDN      6'h12
`define JCIU_OP_PUP      6'h13
`define JCIU_OP_RELOAD   6'h16
`define JCIU_OP_ERCFG    6'h17
`define JCIU_OP_ERSIG    6'h1B
`define JCIU_OP_CALIB    6'h1C
`define JCIU_OP_BULKER   6'h1D
`define JCIU_OP_SAMPLE   6'h1E
`define JCIU_OP_BYPASS   6'h3F

`define JCIU_ADDR_CTRL   12'h000
`define JCIU_ADDR_STAT   12'h004
`define JCIU_ADDR_SIG    12'h008
`define JCIU_CTRL_RST    32'h0000_0000
`define JCIU_CTRL_HOLD   0

`define JCIU_CLK_NS      100
`define JCIU_SWITCH_NS   1000
`define JCIU_SWITCH_CYC  (`JCIU_SWITCH_NS / `JCIU_CLK_NS)

`endif

/* File: rtl/jciu_pkg.sv */
// Purpose: types of the test-port instruction unit
// Assumes: constants live in jciu_params.svh
// Notes: one-hot state and path codes
`default_nettype none
package jciu_pkg;

  typedef enum logic [15:0] {
    TLR   = 16'h0001, RTI   = 16'h0002, SELDR = 16'h0004,
    CAPDR = 16'h0008, SHDR  = 16'h0010, EX1DR = 16'h0020,
    PSDR  = 16'h0040, EX2DR = 16'h0080, UPDR  = 16'h0100,
    SELIR = 16'h0200, CAPIR = 16'h0400, SHIR  = 16'h0800,
    EX1IR = 16'h1000, PSIR  = 16'h2000, EX2IR = 16'h4000,
    UPIR  = 16'h8000
  } jciu_tap_t;

  typedef enum logic [4:0] {
    P_BYP  = 5'h01,
    P_ID   = 5'h02,
    P_CFG  = 5'h04,
    P_QUICK = 5'h08,
    P_SIG  = 5'h10
  } jciu_path_t;

endpackage : jciu_pkg
`default_nettype wire

/* File: rtl/jciu_tap_fsm.sv */
// Purpose: sixteen-state test access port controller
// Assumes: step is a one-cycle pulse per test clock rising edge
// Notes: hold forces test-logic-reset, as does presetn
`timescale 1ns/10ps
`default_nettype none
module jciu_tap_fsm (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // sampled port
  input  wire logic           step,
  input  wire logic           tms,
  input  wire logic           hold,
  // controller state
  output var jciu_pkg::jciu_tap_t state
);
  jciu_pkg::jciu_tap_t next_state;

  // standard transitions, taken only on a sampled rising test clock
  always_comb begin
    unique case (state)
      jciu_pkg::TLR:   next_state = tms ? jciu_pkg::TLR : jciu_pkg::RTI;
      jciu_pkg::RTI:   next_state = tms ? jciu_pkg::SELDR : jciu_pkg::RTI;
      jciu_pkg::SELDR: next_state = tms ? jciu_pkg::SELIR : jciu_pkg::CAPDR;
      jciu_pkg::CAPDR: next_state = tms ? jciu_pkg::EX1DR : jciu_pkg::SHDR;
      jciu_pkg::SHDR:  next_state = tms ? jciu_pkg::EX1DR : jciu_pkg::SHDR;
      jciu_pkg::EX1DR: next_state = tms ? jciu_pkg::UPDR : jciu_pkg::PSDR;
      jciu_pkg::PSDR:  next_state = tms ? jciu_pkg::EX2DR : jciu_pkg::PSDR;
      jciu_pkg::EX2DR: next_state = tms ? jciu_pkg::UPDR : jciu_pkg::SHDR;
      jciu_pkg::UPDR:  next_state = tms ? jciu_pkg::SELDR : jciu_pkg::RTI;
      jciu_pkg::SELIR: next_state = tms ? jciu_pkg::TLR : jciu_pkg::CAPIR;
      jciu_pkg::CAPIR: next_state = tms ? jciu_pkg::EX1IR : jciu_pkg::SHIR;
      jciu_pkg::SHIR:  next_state = tms ? jciu_pkg::EX1IR : jciu_pkg::SHIR;
      jciu_pkg::EX1IR: next_state = tms ? jciu_pkg::UPIR : jciu_pkg::PSIR;
      jciu_pkg::PSIR:  next_state = tms ? jciu_pkg::EX2IR : jciu_pkg::PSIR;
      jciu_pkg::EX2IR: next_state = tms ? jciu_pkg::UPIR : jciu_pkg::SHIR;
      jciu_pkg::UPIR:  next_state = tms ? jciu_pkg::SELDR : jciu_pkg::RTI;
      default:         next_state = jciu_pkg::TLR;
    endcase
  end

  // power-on state is test-logic-reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= jciu_pkg::TLR;
    end else if (hold) begin
      state <= jciu_pkg::TLR;
    end else if (step) begin
      state <= next_state;
    end
  end
endmodule : jciu_tap_fsm
`default_nettype wire

/* File: rtl/jciu_top.sv */
// Purpose: instruction decode and execution behind a test access port
// Assumes: test pins come from outside and are synchronised to pclk
// Notes: nvm modelled as flops; APB gives control and status
`timescale 1ns/10ps
`default_nettype none
`include "jciu_params.svh"
module jciu_top #(
  parameter int                CFG_W      = `JCIU_CFG_W,
  parameter int                QUICK_W    = `JCIU_QUICK_W,
  parameter int                SIG_W      = `JCIU_SIG_W,
  parameter logic [31:0]       ID_VALUE   = 32'h1234_5001, // arbitrary
  parameter int                CAL_CYCLES = 20000,
  parameter int                NVM_CYCLES = 10000
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // test port pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  // analog controls
  output logic      [CFG_W-1:0]  sram_cfg,
  output logic                   amp_zero,
  output logic                   analog_pd,
  output logic                   outputs_hiz
);
  localparam int SW_CYC = `JCIU_SWITCH_CYC;

  // ---- pin synchronisers; stage 0 read only by stage 1
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q <= 3'h0;
      tms_q <= 2'h0;
      tdi_q <= 2'h0;
    end else begin
      tck_q <= {tck_q[1:0], tck};
      tms_q <= {tms_q[0], tms};
      tdi_q <= {tdi_q[0], tdi};
    end
  end
  wire tck_rise = tck_q[1] & ~tck_q[2];
  wire tck_fall = ~tck_q[1] & tck_q[2];

  // ---- apb registers
  logic [31:0] ctrl;
  wire         tap_hold = ctrl[`JCIU_CTRL_HOLD];

  // ---- tap controller
  jciu_pkg::jciu_tap_t st;
  jciu_pkg::jciu_tap_t st_q;
  jciu_tap_fsm u_tap (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (tck_rise),
    .tms     (tms_q[1]),
    .hold    (tap_hold),
    .state   (st)
  );

  // ---- decode
  // unknown, sample and external test all fall back to bypass
  function automatic jciu_pkg::jciu_path_t path_of(
    input logic [`JCIU_IR_W-1:0] c);
    jciu_pkg::jciu_path_t p;
    p = jciu_pkg::P_BYP;
    if (!c[`JCIU_IR_W-1]) begin
      case (c)
        `JCIU_OP_IDCODE:  p = jciu_pkg::P_ID;
        `JCIU_OP_SELFULL:  p = jciu_pkg::P_CFG;
        `JCIU_OP_SELQUICK: p = jciu_pkg::P_QUICK;
        `JCIU_OP_ADDSIG:  p = jciu_pkg::P_SIG;
        default:          p = jciu_pkg::P_BYP;
      endcase
    end
    return p;
  endfunction : path_of

  function automatic logic deferred(input logic [`JCIU_IR_W-1:0] c);
    return c == `JCIU_OP_PRGCFG || c == `JCIU_OP_PRGSIG ||
           c == `JCIU_OP_PRGFUSE || c == `JCIU_OP_LATCH ||
           c == `JCIU_OP_RELOAD || c == `JCIU_OP_ERCFG ||
           c == `JCIU_OP_ERSIG || c == `JCIU_OP_BULKER ||
           c == `JCIU_OP_PDN || c == `JCIU_OP_PUP ||
           c == `JCIU_OP_CALIB;
  endfunction : deferred

  // ---- instruction and data registers
  logic [`JCIU_IR_W-1:0] ir;
  logic [`JCIU_IR_W-1:0] ir_sr;
  logic [`JCIU_IR_W-1:0] pend;
  logic                  pend_v;
  logic                  last_quick;
  logic                  byp_sr;
  logic [31:0]           id_sr;
  logic [CFG_W-1:0]      cfg_sr;
  logic [QUICK_W-1:0]    quick_sr;
  logic [SIG_W-1:0]      sig_sr;
  logic [CFG_W-1:0]      nvm_cfg;
  logic [SIG_W-1:0]      nvm_sig;
  logic                  fuse;

  jciu_pkg::jciu_path_t path;
  assign path = path_of(ir);

  wire in_tlr    = st == jciu_pkg::TLR;
  wire in_rti    = st == jciu_pkg::RTI;
  wire rti_entry = in_rti && st_q != jciu_pkg::RTI;
  wire do_cir    = tck_rise && st == jciu_pkg::CAPIR;
  wire do_sir    = tck_rise && st == jciu_pkg::SHIR;
  wire do_uir    = tck_rise && st == jciu_pkg::UPIR;
  wire do_cdr    = tck_rise && st == jciu_pkg::CAPDR;
  wire do_sdr    = tck_rise && st == jciu_pkg::SHDR;
  wire exec      = rti_entry && pend_v;
  wire [`JCIU_IR_W-1:0] nxt_ir = ir_sr;

  // instruction register: id after reset, loads on update-ir
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir     <= `JCIU_OP_IDCODE;
      ir_sr  <= `JCIU_OP_IDCODE;
      pend   <= `JCIU_OP_BYPASS;
      pend_v <= 1'b0;
      st_q   <= jciu_pkg::TLR;
    end else begin
      st_q <= st;
      if (in_tlr) begin
        ir     <= `JCIU_OP_IDCODE;
        pend_v <= 1'b0;
      end else if (do_uir) begin
        ir     <= nxt_ir;
        pend   <= nxt_ir;
        pend_v <= deferred(nxt_ir);
      end else if (exec) begin
        pend_v <= 1'b0;
      end
      if (do_cir) begin
        ir_sr <= `JCIU_OP_IDCODE;
      end else if (do_sir) begin
        ir_sr <= {tdi_q[1], ir_sr[`JCIU_IR_W-1:1]};
      end
    end
  end

  // shift registers: capture, shift, and nvm reads in update-ir
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_sr     <= 1'b0;
      id_sr      <= 32'h0000_0000;
      cfg_sr     <= '0;
      quick_sr   <= '0;
      sig_sr     <= '0;
      last_quick <= 1'b0;
    end else begin
      if (do_cdr) begin
        byp_sr <= 1'b0;
        id_sr  <= ID_VALUE;
      end else if (do_sdr) begin
        unique case (path)
          jciu_pkg::P_BYP:  byp_sr  <= tdi_q[1];
          jciu_pkg::P_ID:   id_sr   <= {tdi_q[1], id_sr[31:1]};
          jciu_pkg::P_CFG:  cfg_sr  <= {tdi_q[1], cfg_sr[CFG_W-1:1]};
          jciu_pkg::P_QUICK: quick_sr <= {tdi_q[1], quick_sr[QUICK_W-1:1]};
          jciu_pkg::P_SIG:  sig_sr  <= {tdi_q[1], sig_sr[SIG_W-1:1]};
        endcase
      end
      if (do_uir) begin
        if (nxt_ir == `JCIU_OP_SELFULL)  last_quick <= 1'b0;
        if (nxt_ir == `JCIU_OP_SELQUICK) last_quick <= 1'b1;
        if (nxt_ir == `JCIU_OP_RDCFG) begin
          cfg_sr   <= nvm_cfg;
          quick_sr <= nvm_cfg[QUICK_W-1:0];
        end
        if (nxt_ir == `JCIU_OP_RDSIG) sig_sr <= nvm_sig;
      end
    end
  end

  // shift-out bit; configuration paths read zero once the fuse is set
  logic so_bit;
  always_comb begin
    so_bit = byp_sr;
    unique case (path)
      jciu_pkg::P_BYP:  so_bit = byp_sr;
      jciu_pkg::P_ID:   so_bit = id_sr[0];
      jciu_pkg::P_CFG:  so_bit = cfg_sr[0] & ~fuse;
      jciu_pkg::P_QUICK: so_bit = quick_sr[0] & ~fuse;
      jciu_pkg::P_SIG:  so_bit = sig_sr[0];
    endcase
  end
  wire shifting = st == jciu_pkg::SHDR || st == jciu_pkg::SHIR;

  // tdo changes on the falling test clock, as the port expects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (st == jciu_pkg::SHIR) ? ir_sr[0] : so_bit;
      tdo_oe <= shifting;
    end
  end

  // ---- deferred execution on idle entry
  logic [15:0] cal_cnt;
  logic [15:0] nvm_cnt;
  wire is_nvm_op = pend == `JCIU_OP_PRGCFG || pend == `JCIU_OP_PRGSIG ||
                   pend == `JCIU_OP_PRGFUSE || pend == `JCIU_OP_ERCFG ||
                   pend == `JCIU_OP_ERSIG || pend == `JCIU_OP_BULKER;
  wire nvm_busy = nvm_cnt != 16'h0000;
  wire cal_busy = cal_cnt != 16'h0000;

  // programming only sets bits; erases clear to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_cfg <= '0;
      nvm_sig <= '0;
      fuse    <= 1'b0;
    end else if (exec) begin
      unique case (pend)
        `JCIU_OP_PRGCFG:  nvm_cfg <= nvm_cfg | cfg_sr;
        `JCIU_OP_PRGSIG:  nvm_sig <= nvm_sig | sig_sr;
        `JCIU_OP_PRGFUSE: fuse    <= 1'b1;
        `JCIU_OP_ERCFG:   nvm_cfg <= '0;
        `JCIU_OP_ERSIG:   nvm_sig <= '0;
        `JCIU_OP_BULKER: begin
          nvm_cfg <= '0;
          nvm_sig <= '0;
          fuse    <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // sram, power and calibration; counters run with no port activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_cfg  <= '0;
      analog_pd <= 1'b0;
      cal_cnt   <= 16'h0000;
      nvm_cnt   <= 16'h0000;
    end else begin
      if (cal_busy) cal_cnt <= cal_cnt - 16'h0001;
      if (nvm_busy) nvm_cnt <= nvm_cnt - 16'h0001;
      if (exec) begin
        if (is_nvm_op) nvm_cnt <= NVM_CYCLES[15:0];
        unique case (pend)
          `JCIU_OP_LATCH: begin
            if (last_quick) sram_cfg[QUICK_W-1:0] <= quick_sr;
            else            sram_cfg <= cfg_sr;
          end
          `JCIU_OP_RELOAD: sram_cfg  <= nvm_cfg;
          `JCIU_OP_PDN:    analog_pd <= 1'b1;
          `JCIU_OP_PUP:    analog_pd <= 1'b0;
          `JCIU_OP_CALIB:  cal_cnt   <= CAL_CYCLES[15:0];
          default: ;
        endcase
      end
    end
  end
  assign amp_zero    = cal_busy;
  assign outputs_hiz = analog_pd;

  // ---- apb slave, zero wait states, error on unmapped address
  wire        acc      = psel & penable;
  wire        hit_ctrl = paddr == `JCIU_ADDR_CTRL;
  wire        hit_stat = paddr == `JCIU_ADDR_STAT;
  wire        hit_sig  = paddr == `JCIU_ADDR_SIG;
  wire        hit      = hit_ctrl | hit_stat | hit_sig;
  wire [31:0] stat_v   = {12'h000, ir, 1'b0, path,
                          2'h0, fuse, last_quick,
                          nvm_busy, pend_v, cal_busy, analog_pd};
  wire [31:0] rd_mux   = hit_ctrl ? ctrl :
                         hit_stat ? stat_v :
                         hit_sig  ? {16'h0000, nvm_sig} : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = rd_mux;

  // only the hold bit is writable; it parks the controller in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `JCIU_CTRL_RST;
    end else if (acc && pwrite && hit_ctrl) begin
      ctrl <= {31'h0, pwdata[`JCIU_CTRL_HOLD]};
    end
  end

  // ---- assertions
  property p_byp_ones;
    @(posedge pclk) disable iff (!presetn)
    ir[`JCIU_IR_W-1] |-> path == jciu_pkg::P_BYP;
  endproperty
  a_byp_ones: assert property (p_byp_ones)
    else $error("leading-one code not bypass");

  property p_byp_fallback;
    @(posedge pclk) disable iff (!presetn)
    (ir == `JCIU_OP_SAMPLE || ir == `JCIU_OP_EXTEST)
      |-> path == jciu_pkg::P_BYP;
  endproperty
  a_byp_fallback: assert property (p_byp_fallback)
    else $error("sample or extest not bypass");

  property p_tlr_id;
    @(posedge pclk) disable iff (!presetn)
    in_tlr ##1 !tap_hold |-> path == jciu_pkg::P_ID;
  endproperty
  a_tlr_id: assert property (p_tlr_id)
    else $error("id not selected after reset state");

  property p_capir;
    @(posedge pclk) disable iff (!presetn)
    do_cir |=> ir_sr == `JCIU_OP_IDCODE;
  endproperty
  a_capir: assert property (p_capir)
    else $error("capture-ir did not load id code");

  property p_deferred;
    @(posedge pclk) disable iff (!presetn)
    !rti_entry |-> ##1 $stable(nvm_cfg) && $stable(fuse);
  endproperty
  a_deferred: assert property (p_deferred)
    else $error("nvm changed outside idle entry");

  property p_switch;
    @(posedge pclk) disable iff (!presetn)
    (rti_entry && pend_v && pend == `JCIU_OP_RELOAD)
      |-> ##[1:SW_CYC] sram_cfg == nvm_cfg;
  endproperty
  a_switch: assert property (p_switch)
    else $error("sram switch too slow");

  property p_cal;
    @(posedge pclk) disable iff (!presetn)
    (rti_entry && pend_v && pend == `JCIU_OP_CALIB)
      |=> amp_zero [*8];
  endproperty
  a_cal: assert property (p_cal)
    else $error("amps not held during calibration");

  property p_bulk;
    @(posedge pclk) disable iff (!presetn)
    (exec && pend == `JCIU_OP_BULKER)
      |=> !fuse && nvm_sig == '0 && nvm_cfg == '0;
  endproperty
  a_bulk: assert property (p_bulk)
    else $error("bulk erase left bits set");

  property p_fuse_only_bulk;
    @(posedge pclk) disable iff (!presetn)
    $fell(fuse) |-> $past(pend) == `JCIU_OP_BULKER;
  endproperty
  a_fuse_only_bulk: assert property (p_fuse_only_bulk)
    else $error("fuse cleared by other code");

  property p_prog_or;
    @(posedge pclk) disable iff (!presetn)
    (exec && pend == `JCIU_OP_PRGSIG)
      |=> nvm_sig == ($past(nvm_sig) | $past(sig_sr));
  endproperty
  a_prog_or: assert property (p_prog_or)
    else $error("program did not or into nvm");

  property p_pd;
    @(posedge pclk) disable iff (!presetn)
    $changed(analog_pd) |-> $past(exec) &&
      ($past(pend) == `JCIU_OP_PDN || $past(pend) == `JCIU_OP_PUP);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power state changed without command");

  c_latch_quick: cover property (@(posedge pclk) disable iff (!presetn)
    exec && pend == `JCIU_OP_LATCH && last_quick);
  c_fuse_set: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(fuse));
  c_cal_done: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(cal_busy));
  c_cfg_shift: cover property (@(posedge pclk) disable iff (!presetn)
    do_sdr && path == jciu_pkg::P_CFG);
endmodule : jciu_top
`default_nettype wire

/* File: tb/jciu_host.sv */
// Purpose: test port host driving tck, tms and tdi
// Assumes: pclk 100 ns, tck period 800 ns
// Notes: tck stands low between steps; pins move after pclk rise
`timescale 1ns/10ps
`default_nettype none
module jciu_host (
  // clock
  input  wire logic pclk,
  // test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  logic q;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period, tdo taken at the rise
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    q = tdo;
    repeat (4) @(posedge pclk);
    tck <= 1'b0;
  endtask : step
  // five highs reach test-logic-reset from anywhere
  task automatic park();
    repeat (5) step(1'b1, ~tdi);
  endtask : park
  // ends in update-ir, so a data scan may follow at once
  task automatic ir_scan(input logic [5:0] c);
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < 6; i++) step(i == 5, c[i]);
    step(1'b1, ~tdi);
  endtask : ir_scan
  // lsb first, ends in run-test/idle
  task automatic dr_scan(input int n, input logic [111:0] di,
                         output logic [111:0] dq);
    dq = '0;
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i]);
      dq[i] = q;
    end
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask : dr_scan
endmodule : jciu_host
`default_nettype wire

/* File: tb/jciu_top_tb.sv */
// Purpose: self-checking bench of the test-port instruction unit
// Assumes: short calibration and nvm counts
// Notes: xorshift data from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "jciu_params.svh"
module jciu_top_tb;
  localparam logic [31:0] IDV = 32'h5A3C_0F01; // arbitrary
  logic         pclk, presetn, psel, penable, pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, seed;
  logic         pready, pslverr, tck, tms, tdi, tdo, tdo_oe;
  logic         er, oe_seen;
  logic         amp_zero, analog_pd, outputs_hiz;
  logic [111:0] sram_cfg, a, b, q, r;
  int           fails, total_checks, cyc;
  jciu_top #(.ID_VALUE(IDV), .CAL_CYCLES(20), .NVM_CYCLES(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .sram_cfg(sram_cfg),
    .amp_zero(amp_zero), .analog_pd(analog_pd),
    .outputs_hiz(outputs_hiz));
  jciu_host host (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi),
                  .tdo(tdo));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [111:0] r112();
    logic [127:0] t;
    t = {rnd(), rnd(), rnd(), rnd()};
    return t[111:0];
  endfunction : r112
  // quick latch keeps the upper part of the sram image
  function automatic logic [111:0] quick(input logic [111:0] s,
                                         input logic [111:0] k);
    return {s[111:40], k[39:0]};
  endfunction : quick
  task automatic chk(input string n, input logic [111:0] e,
                     input logic [111:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // apb read or write, waits on pready under the timeout
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel at once
    @(posedge pclk);
  endtask : apb
  // deferred codes: enter idle, then allow under one microsecond
  task automatic run(input logic [5:0] c);
    host.ir_scan(c);
    host.step(1'b0, ~tdi);
    repeat (5) @(posedge pclk);
  endtask : run
  // address then shift straight from update-ir
  task automatic ld(input logic [5:0] c, input int n,
                    input logic [111:0] d);
    host.ir_scan(c);
    host.dr_scan(n, d, r);
  endtask : ld
  task automatic rdb(input logic [5:0] c, input logic [5:0] ad,
                     input int n);
    host.ir_scan(c);
    ld(ad, n, 112'h0);
  endtask : rdb
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    cyc++;
    if (tdo_oe === 1'b1) oe_seen <= 1'b1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    logic [5:0] bc [5];
    seed = 32'h0000_24A8;
    {presetn, psel, penable, pwrite, paddr, pwdata, oe_seen} = '0;
    bc = '{6'h00, 6'h1E, 6'h3F, 6'h04, 6'h20};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    host.park();
    host.step(1'b0, 1'b0);
    host.dr_scan(32, 112'h0, r);
    chk("id", IDV, r[31:0]);
    // bypass is one stage: a zero, then the first bit in
    foreach (bc[i]) begin
      a = r112();
      ld(i == 4 ? {1'b1, a[8:4]} : bc[i], 2, a);
      chk("bypass", {a[0], 1'b0}, r[1:0]);
    end
    a = r112();
    b = r112();
    q = r112();
    ld(`JCIU_OP_SELFULL, 112, a);
    run(`JCIU_OP_PRGCFG);
    ld(`JCIU_OP_SELFULL, 112, b);
    host.ir_scan(`JCIU_OP_LATCH);
    chk("latch early", 112'h0, sram_cfg);
    host.step(1'b0, ~tdi);
    repeat (5) @(posedge pclk);
    chk("latch", b, sram_cfg);
    run(`JCIU_OP_RELOAD);
    chk("reload", a, sram_cfg);
    ld(`JCIU_OP_SELQUICK, 40, q);
    run(`JCIU_OP_LATCH);
    chk("quick", quick(a, q), sram_cfg);
    rdb(`JCIU_OP_RDCFG, `JCIU_OP_SELFULL, 112);
    chk("read_config_nvm", a, r);
    ld(`JCIU_OP_SELFULL, 112, b);
    run(`JCIU_OP_PRGCFG);
    rdb(`JCIU_OP_RDCFG, `JCIU_OP_SELFULL, 112);
    chk("or", a | b, r);
    ld(`JCIU_OP_ADDSIG, 16, q);
    run(`JCIU_OP_PRGSIG);
    rdb(`JCIU_OP_RDSIG, `JCIU_OP_ADDSIG, 16);
    chk("sig", q[15:0], r);
    run(`JCIU_OP_ERSIG);
    rdb(`JCIU_OP_RDSIG, `JCIU_OP_ADDSIG, 16);
    chk("ersig", 112'h0, r);
    run(`JCIU_OP_ERCFG);
    rdb(`JCIU_OP_RDCFG, `JCIU_OP_SELFULL, 112);
    chk("ercfg", 112'h0, r);
    ld(`JCIU_OP_SELFULL, 112, b);
    run(`JCIU_OP_PRGCFG);
    run(`JCIU_OP_PRGFUSE);
    rdb(`JCIU_OP_RDCFG, `JCIU_OP_SELFULL, 112);
    chk("fuse hide", 112'h0, r);
    apb(1'b0, `JCIU_ADDR_STAT, 32'h0);
    chk("fuse", 1'b1, rd[5]);
    run(`JCIU_OP_BULKER);
    apb(1'b0, `JCIU_ADDR_STAT, 32'h0);
    chk("fuse clr", 1'b0, rd[5]);
    rdb(`JCIU_OP_RDCFG, `JCIU_OP_SELFULL, 112);
    chk("bulk", 112'h0, r);
    host.ir_scan(`JCIU_OP_PDN);
    chk("pd early", 1'b0, analog_pd);
    host.step(1'b0, ~tdi);
    repeat (5) @(posedge pclk);
    chk("pd", 2'b11, {analog_pd, outputs_hiz});
    ld(`JCIU_OP_IDCODE, 32, 112'h0);
    chk("id pd", IDV, r[31:0]);
    run(`JCIU_OP_PUP);
    chk("pu", 2'b00, {analog_pd, outputs_hiz});
    run(`JCIU_OP_CALIB);
    chk("cal", 1'b1, amp_zero);
    repeat (30) @(posedge pclk);
    chk("cal done", 1'b0, amp_zero);
    // hold parks the controller, so the id path must come back
    apb(1'b1, `JCIU_ADDR_CTRL, 32'h1);
    apb(1'b0, `JCIU_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b1, `JCIU_ADDR_CTRL, 32'h0);
    host.step(1'b0, 1'b0);
    host.dr_scan(32, 112'h0, r);
    chk("id hold", IDV, r[31:0]);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 33'h1_0000_0000, {er, rd});
    host.park();
    chk("oe", 2'b10, {oe_seen, tdo_oe});
    end_of_test();
  end
endmodule : jciu_top_tb
`default_nettype wire
